// ---- rtl/ceis_edge_select.sv ----
`timescale 1ns/10ps
module ceis_edge_select (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire ceis_pkg::ceis_req_s i_req,
    input wire logic [ceis_pkg::NUM_CMP-1:0] i_cmp_out,
    output logic [7:0] o_rdata,
    output logic o_wait,
    output logic [ceis_pkg::NUM_CMP-1:0] o_cmp_irq,
    output logic [7:0] o_analog_pin_config
);
    // =========================================
    // register file
    logic [7:0] rise_enable_low_reg;  // rising enables 0..7
    logic [7:0] fall_enable_low_reg;  // falling enables 0..7
    logic [7:0] rise_enable_high_reg; // rising enable 8
    logic [7:0] fall_enable_high_reg; // falling enable 8
    logic [7:0] analog_pin_config_reg; // analog/digital select
    logic wait_reg;                    // wait cycle in progress
    logic [7:0] rdata_reg;
    logic [7:0] rise_enable_low_next;
    logic [7:0] fall_enable_low_next;
    logic [7:0] rise_enable_high_next;
    logic [7:0] fall_enable_high_next;
    logic [7:0] analog_next;

    // merge a byte or single-bit write into a register
    function automatic logic [7:0] merge_write(input logic [7:0] old,
                                               input ceis_pkg::ceis_req_s req);
        logic [7:0] res;
        res = old;
        if (req.bit_op) begin
            res[req.bit_sel] = req.wdata[0];
        end else begin
            res = req.wdata;
        end
        return res;
    endfunction : merge_write

    // write decode for one address
    function automatic logic hit(input ceis_pkg::ceis_req_s req, input logic [15:0] a);
        return req.wr && (req.addr == a);
    endfunction : hit

    // next values of the enable registers and the analog config register
    always_comb begin
        rise_enable_low_next = rise_enable_low_reg;
        fall_enable_low_next = fall_enable_low_reg;
        rise_enable_high_next = rise_enable_high_reg;
        fall_enable_high_next = fall_enable_high_reg;
        analog_next = analog_pin_config_reg;
        if (hit(i_req, ceis_pkg::ADDR_RISE_LOW)) begin
            rise_enable_low_next = merge_write(rise_enable_low_reg, i_req);
        end
        if (hit(i_req, ceis_pkg::ADDR_FALL_LOW)) begin
            fall_enable_low_next = merge_write(fall_enable_low_reg, i_req);
        end
        if (hit(i_req, ceis_pkg::ADDR_RISE_HIGH)) begin
            rise_enable_high_next = merge_write(rise_enable_high_reg, i_req)
                                    & ceis_pkg::HIGH_MASK;
        end
        if (hit(i_req, ceis_pkg::ADDR_FALL_HIGH)) begin
            fall_enable_high_next = merge_write(fall_enable_high_reg, i_req)
                                    & ceis_pkg::HIGH_MASK;
        end
        // analog config completes on the wait cycle
        if (wait_reg) begin
            analog_next = merge_write(analog_pin_config_reg, i_req);
        end
    end

    // enable registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rise_enable_low_reg <= ceis_pkg::RESET_ENABLE;
            fall_enable_low_reg <= ceis_pkg::RESET_ENABLE;
            rise_enable_high_reg <= ceis_pkg::RESET_ENABLE;
            fall_enable_high_reg <= ceis_pkg::RESET_ENABLE;
        end else begin
            rise_enable_low_reg <= rise_enable_low_next;
            fall_enable_low_reg <= fall_enable_low_next;
            rise_enable_high_reg <= rise_enable_high_next;
            fall_enable_high_reg <= fall_enable_high_next;
        end
    end

    // analog configuration register with its wait cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            analog_pin_config_reg <= ceis_pkg::RESET_ANALOG;
            wait_reg <= 1'b0;
        end else begin
            wait_reg <= hit(i_req, ceis_pkg::ADDR_ANALOG_CFG) && !wait_reg;
            analog_pin_config_reg <= analog_next;
        end
    end

    // registered read data; unmapped reads give zero
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_reg <= 8'h00;
        end else if (i_req.rd) begin
            case (i_req.addr)
                ceis_pkg::ADDR_RISE_LOW: rdata_reg <= rise_enable_low_reg;
                ceis_pkg::ADDR_FALL_LOW: rdata_reg <= fall_enable_low_reg;
                ceis_pkg::ADDR_RISE_HIGH: rdata_reg <= rise_enable_high_reg;
                ceis_pkg::ADDR_FALL_HIGH: rdata_reg <= fall_enable_high_reg;
                ceis_pkg::ADDR_ANALOG_CFG: rdata_reg <= analog_pin_config_reg;
                default: rdata_reg <= 8'h00;
            endcase
        end
    end

    // =========================================
    // comparator edge detection
    logic [ceis_pkg::NUM_CMP-1:0] sync1_reg; // first stage
    logic [ceis_pkg::NUM_CMP-1:0] sync2_reg; // second stage
    logic [ceis_pkg::NUM_CMP-1:0] prev_reg;  // last sampled level
    logic [ceis_pkg::NUM_CMP-1:0] irq_reg;
    logic [ceis_pkg::NUM_CMP-1:0] rise_en;
    logic [ceis_pkg::NUM_CMP-1:0] fall_en;

    assign rise_en = {rise_enable_high_reg[0],
                      rise_enable_low_reg[ceis_pkg::CH_CMP0+1],
                      rise_enable_low_reg[ceis_pkg::CH_CMP0]};
    assign fall_en = {fall_enable_high_reg[0],
                      fall_enable_low_reg[ceis_pkg::CH_CMP0+1],
                      fall_enable_low_reg[ceis_pkg::CH_CMP0]};

    // synchronise and detect per comparator
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            prev_reg <= '0;
            irq_reg <= '0;
        end else begin
            sync1_reg <= i_cmp_out;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
            irq_reg <= (rise_en & sync2_reg & ~prev_reg)
                     | (fall_en & ~sync2_reg & prev_reg);
        end
    end

    assign o_rdata = rdata_reg;
    assign o_wait = wait_reg;
    assign o_cmp_irq = irq_reg;
    assign o_analog_pin_config = analog_pin_config_reg;

    // =========================================
    // assertions
    // enabled rising edge seen on one channel
    sequence rise_seen(int i);
        !prev_reg[i] && sync2_reg[i] && rise_en[i];
    endsequence

    // enabled falling edge seen on one channel
    sequence fall_seen(int i);
        prev_reg[i] && !sync2_reg[i] && fall_en[i];
    endsequence

    // synchronised level unchanged from the cycle before
    sequence level_still(int i);
        sync2_reg[i] == prev_reg[i];
    endsequence

    // per comparator: enabled edges raise pulses, quiet levels and disabled edges raise none
    generate
        for (genvar g = 0; g < ceis_pkg::NUM_CMP; g++) begin : g_chk
            rise_irq_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
                rise_seen(g) |=> irq_reg[g])
                else $error("rising edge missed");
            fall_irq_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
                fall_seen(g) |=> irq_reg[g])
                else $error("falling edge missed");
            // a pulse ends unless a new edge follows at once
            irq_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
                irq_reg[g] ##0 level_still(g) |=> !irq_reg[g])
                else $error("irq longer than one cycle");
            // no edge on the synchronised level, no request
            quiet_irq_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
                level_still(g) |=> !irq_reg[g])
                else $error("irq without an edge");
            no_en_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
                !rise_en[g] && !fall_en[g] |=> !irq_reg[g])
                else $error("irq with edge disabled");
        end
    endgenerate

    high_mask_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (rise_enable_high_reg[7:1] == 7'h00) && (fall_enable_high_reg[7:1] == 7'h00))
        else $error("high register upper bits set");
    byte_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        hit(i_req, ceis_pkg::ADDR_RISE_LOW) && !i_req.bit_op
        |=> rise_enable_low_reg == $past(i_req.wdata))
        else $error("byte write not stored");
    wait_one_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        hit(i_req, ceis_pkg::ADDR_ANALOG_CFG) && !wait_reg |=> wait_reg ##1 !wait_reg)
        else $error("wait cycle wrong length");
    analog_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !wait_reg |=> analog_pin_config_reg == $past(analog_pin_config_reg))
        else $error("analog config changed without write");

    // read of the fall high register shows only its bit 0
    high_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_req.rd && (i_req.addr == ceis_pkg::ADDR_FALL_HIGH) |=> rdata_reg[7:1] == 7'h00)
        else $error("high register read shows upper bits");
    // single-bit write lands in the selected bit
    bit_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        hit(i_req, ceis_pkg::ADDR_FALL_LOW) && i_req.bit_op
        |=> fall_enable_low_reg[$past(i_req.bit_sel)] == $past(i_req.wdata[0]))
        else $error("bit write not stored");
    // analog config takes the byte held through the wait cycle
    analog_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wait_reg && hit(i_req, ceis_pkg::ADDR_ANALOG_CFG) && !i_req.bit_op
        |=> analog_pin_config_reg == $past(i_req.wdata))
        else $error("analog config write not stored");
endmodule : ceis_edge_select

// ---- rtl/ceis_pkg.sv ----
// Notes on behaviour
// - rise/fall pair picks none, fall, rise, both
// - registers set comparator edges; channel 8 high bit0
// - reset clears all four enable registers
// - bit and byte writes both supported
// - pin select bit zero means analog input
// - analog config write inserts one wait cycle
// - channels 6,7,8 map to comparators 0,1,2
package ceis_pkg;
    // =========================================
    // register addresses
    localparam logic [15:0] ADDR_RISE_LOW = 16'hFF48;
    localparam logic [15:0] ADDR_FALL_LOW = 16'hFF49;
    localparam logic [15:0] ADDR_RISE_HIGH = 16'hFF4A;
    localparam logic [15:0] ADDR_FALL_HIGH = 16'hFF4B;
    localparam logic [15:0] ADDR_ANALOG_CFG = 16'hFF2E;
    // reset values
    localparam logic [7:0] RESET_ENABLE = 8'h00;
    localparam logic [7:0] RESET_ANALOG = 8'h00;
    // implemented bit of the high registers
    localparam logic [7:0] HIGH_MASK = 8'h01;
    // channel positions of comparators 0 and 1 in the low registers
    localparam int CH_CMP0 = 6;
    // number of comparators
    localparam int NUM_CMP = 3;
    // cpu access request carrier
    typedef struct packed {
        logic        wr;      // write strobe
        logic        rd;      // read strobe
        logic        bit_op;  // single-bit manipulation
        logic [2:0]  bit_sel; // bit number for bit_op
        logic [15:0] addr;    // byte address
        logic [7:0]  wdata;   // byte data, or bit value in bit 0
    } ceis_req_s;
endpackage : ceis_pkg

// ---- verification/ceis_cmp_model.sv ----
`timescale 1ns/10ps
// ==========================================
// comparator outputs seen by the edge selector
module ceis_cmp_model (
    input wire logic i_clk,
    output logic [2:0] o_level
);
    // comparator pins only ever feed the block
    // levels change only just after a rising edge
    task automatic drive(input logic [2:0] lvl);
        @(posedge i_clk);
        o_level <= lvl;
    endtask : drive
    // comparators idle low at power up
    initial o_level = 3'h0;
endmodule : ceis_cmp_model

// ---- verification/tb.sv ----
`timescale 1ns/10ps
// ==========================================
// bench for the comparator edge selector
module tb;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    ceis_pkg::ceis_req_s req = '0; // cpu request
    logic [2:0] cmp;
    logic [7:0] rdata;
    logic [7:0] apc;
    logic wt;
    logic [2:0] irq;
    int n_mismatch = 0;
    int tests_run = 0;
    logic [2:0] rise_m = 3'h0; // model rise enables
    logic [2:0] fall_m = 3'h0; // model fall enables
    logic [2:0] lvl_m = 3'h0; // model comparator levels
    ceis_edge_select dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req), .i_cmp_out(cmp),
        .o_rdata(rdata), .o_wait(wt), .o_cmp_irq(irq), .o_analog_pin_config(apc));
    ceis_cmp_model cmpm (.i_clk(i_clk), .o_level(cmp));
    // 100 ns clock
    always #50 i_clk = ~i_clk;
    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // verdict and end of run
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    // write; the analog config write is held through its wait cycle
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b,
                      input logic [2:0] s);
        @(posedge i_clk);
        req <= '{wr: 1'b1, rd: 1'b0, bit_op: b, bit_sel: s, addr: a, wdata: d};
        @(posedge i_clk);
        // plain writes end on the taking edge, the analog write one edge later
        if (a != ceis_pkg::ADDR_ANALOG_CFG) begin
            req.wr <= 1'b0;
        end
        #1 chk({7'h00, wt}, {7'h00, a == ceis_pkg::ADDR_ANALOG_CFG});
        if (a == ceis_pkg::ADDR_ANALOG_CFG) begin
            @(posedge i_clk);
            req.wr <= 1'b0;
            #1 chk({7'h00, wt}, 8'h00);
        end
    endtask : wr
    // read; data is valid the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge i_clk);
        req.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd
    // move comparators and count pulses against the model
    task automatic edges(input logic [2:0] lvl);
        logic [2:0] exp;
        exp = (lvl & ~lvl_m & rise_m) | (~lvl & lvl_m & fall_m);
        lvl_m = lvl;
        cmpm.drive(lvl);
        for (int k = 0; k < 6; k++) begin
            @(posedge i_clk);
            #1 chk({5'h00, irq}, (k == 2) ? {5'h00, exp} : 8'h00);
        end
    endtask : edges
    // hang guard
    initial begin
        #2000000;
        n_mismatch++;
        stop_test();
    end
    // main sequence
    initial begin
        logic [7:0] d;
        void'($urandom(32'h1390A1BC));
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(ceis_pkg::ADDR_RISE_LOW, 8'h00);
        rd(ceis_pkg::ADDR_FALL_LOW, 8'h00);
        rd(ceis_pkg::ADDR_RISE_HIGH, 8'h00);
        rd(ceis_pkg::ADDR_FALL_HIGH, 8'h00);
        rd(16'hFF40, 8'h00);
        $display("test reset values done");
        // every pair code on every channel
        for (int m = 0; m < 64; m++) begin
            rise_m = m[2:0];
            fall_m = m[5:3];
            // unused bits 0..5 written as zero; high registers take a single-bit write of bit 0
            wr(ceis_pkg::ADDR_RISE_LOW, {rise_m[1:0], 6'h00}, 1'b0, 3'h0);
            wr(ceis_pkg::ADDR_FALL_LOW, {fall_m[1:0], 6'h00}, 1'b0, 3'h0);
            wr(ceis_pkg::ADDR_RISE_HIGH, {7'h00, rise_m[2]}, 1'b1, 3'h0);
            wr(ceis_pkg::ADDR_FALL_HIGH, {7'h00, fall_m[2]}, 1'b1, 3'h0);
            rd(ceis_pkg::ADDR_FALL_HIGH, {7'h00, fall_m[2]});
            rd(ceis_pkg::ADDR_RISE_LOW, {rise_m[1:0], 6'h00});
            edges(3'($urandom));
            edges(~lvl_m);
        end
        // single-bit clear of channel 6 leaves channel 7 set
        wr(ceis_pkg::ADDR_FALL_LOW, 8'h00, 1'b1, 3'h6);
        rd(ceis_pkg::ADDR_FALL_LOW, {fall_m[1], 7'h00});
        $display("test edge selection done");
        d = 8'($urandom);
        // the clock keeps running through every analog write
        wr(ceis_pkg::ADDR_ANALOG_CFG, d, 1'b0, 3'h0);
        #1 chk(apc, d);
        d[2] = 1'b0;
        wr(ceis_pkg::ADDR_ANALOG_CFG, 8'h00, 1'b1, 3'h2);
        rd(ceis_pkg::ADDR_ANALOG_CFG, d);
        chk(apc, d);
        $display("test analog config done");
        stop_test();
    end
endmodule : tb
